// [hdl/pecd_pkg.sv]
/*
 * shared constants and types of the guarded serial word-memory decoder.
 * assumes an APB register port on core_clk and a serial link on its own clock.
 */
`default_nettype none

package pecd_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0]  CTRL_OFS      = 8'h00;
	localparam logic [7:0]  STATUS_OFS    = 8'h04;
	localparam logic [7:0]  GUARD_OFS     = 8'h08;
	localparam int          CTRL_VAR_LSB  = 0;
	localparam logic [1:0]  CTRL_VAR_RST  = 2'h3;
	localparam int          ST_WEN_POS    = 0;
	localparam int          ST_CLR_POS    = 1;
	localparam int          ST_FRZ_POS    = 2;
	localparam int          ST_UNL_POS    = 3;

	// ****************************************************************
	// instruction encodings
	// ****************************************************************
	localparam logic [1:0]  OPC_MISC      = 2'h0;
	localparam logic [1:0]  OPC_WRITE     = 2'h1;
	localparam logic [1:0]  OPC_READ      = 2'h2;
	localparam logic [1:0]  OPC_CLEAR     = 2'h3;
	localparam logic [1:0]  TOP_DIS       = 2'h0;
	localparam logic [1:0]  TOP_FILL      = 2'h1;
	localparam logic [1:0]  TOP_EN        = 2'h3;
	localparam logic [3:0]  DATA_LAST     = 4'hF;
	localparam logic [3:0]  NARROW_LAST   = 4'h5;
	localparam logic [3:0]  WIDE_LAST     = 4'h7;
	localparam logic [4:0]  WORD_BITS     = 5'h10;
	localparam logic [4:0]  NARROW_BITS   = 5'h06;
	localparam logic [4:0]  WIDE_BITS     = 5'h08;
	localparam logic [7:0]  GUARD_RST     = 8'hFF;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_HOLD} pecd_state_e;

	typedef struct packed {
		logic [7:0] guard;
		logic       unlocked;
		logic       frozen;
		logic       cleared;
		logic       wen;
	} pecd_stat_s;

endpackage : pecd_pkg

`default_nettype wire

// [hdl/pecd_sync.sv]
/*
 * two-flop level synchroniser, width set by parameter.
 * assumes the input is a level that stays put for several destination clocks.
 */
`default_nettype none

module pecd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,  // destination clock
	input  wire logic [W-1:0] d,    // level from the other domain
	output logic      [W-1:0] q     // synchronised level
);

	logic [W-1:0] meta_reg;

	// ****************************************************************
	// two stages, first one read only by the second
	// ****************************************************************
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end

endmodule : pecd_sync

`default_nettype wire

// [hdl/pecd_top.sv]
/*
 * serial instruction decoder of a guarded 16-bit word memory, with APB view.
 * assumes the host drives the link clock and selects by chip_select high.
 */
// Contract
// - after guard freeze, guard register can never change again; the system reset still reloads it to all ones and clears the freeze
// - unlock is 1,00,11xx with both pins high, directly before guard changes
// - 1,10,address with guard select low reads memory from that address
// - 1,00,11xx with guard select low and enable high enables programming
// - 1,01,address,data programs word only if address unprotected
// - 1,00,01xx,data fills all words, only while guard is cleared
// - 1,00,00xx with guard select low disables programming
// - 1,10 with guard select high returns the guard address
// - 1,11,all ones with both pins high clears the guard
// - 1,01,address with both pins high loads guard; that word and higher protected
// - freeze is 1,00,all zeros with both pins high
// - smallest variant uses only the low four address bits
// - 2048-bit variant uses only the low seven address bits
// - guard select not held high means instruction targets the array
// - read sends one zero dummy bit, then words continuously
// - programming disabled after reset until enable executes
// - unlock accepted only while programming is enabled
`default_nettype none

module pecd_top (
	input  wire logic        core_clk,           // core clock, 100 MHz
	input  wire logic        resetn,             // synchronous reset, active low
	input  wire logic        psel,               // apb select
	input  wire logic        penable,            // apb access phase
	input  wire logic        pwrite,             // apb write
	input  wire logic [7:0]  paddr,              // apb byte address
	input  wire logic [31:0] pwdata,             // apb write data
	output logic      [31:0] prdata,             // apb read data
	output logic             pready,             // apb ready
	output logic             pslverr,            // apb error on unmapped address
	input  wire logic        serial_shift_clock, // link clock
	input  wire logic        chip_select,        // link select, low resets decoder
	input  wire logic        serial_in_pin,      // link data in
	input  wire logic        guard_select_pin,   // targets guard register
	input  wire logic        program_enable_pin, // gates programming
	output logic             serial_out_pin,     // link data out
	output logic             serial_out_en       // high while driving data out
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	pecd_pkg::pecd_state_e state_reg;
	logic [15:0]          mem [256];
	logic [3:0]           cnt_reg;
	logic [1:0]           opc_reg;
	logic [7:0]           addr_reg;
	logic [15:0]          data_reg;
	logic                 pe_all_reg;
	logic                 pre_all_reg;
	logic                 wen_reg;
	logic [7:0]           guard_reg;
	logic                 cleared_reg;
	logic                 frozen_reg;
	logic                 unlock_reg;
	logic [15:0]          out_sh_reg;
	logic [4:0]           out_cnt_reg;
	logic [7:0]           rd_addr_reg;
	logic                 guard_rd_reg;
	logic [1:0]           var_reg;
	logic [1:0]           var_lk;
	logic                 lk_rstn;
	pecd_pkg::pecd_stat_s stat_lk;
	pecd_pkg::pecd_stat_s stat_core;
	logic [31:0]          rd_val;
	logic                 hit;

	// ****************************************************************
	// crossings
	// ****************************************************************
	pecd_sync #(.W(2)) u_var_sync (
		.clk (serial_shift_clock),
		.d   (var_reg),
		.q   (var_lk)
	);

	pecd_sync #(.W(1)) u_rst_sync (
		.clk (serial_shift_clock),
		.d   (resetn),
		.q   (lk_rstn)
	);

	pecd_sync #(.W(12)) u_stat_sync (
		.clk (core_clk),
		.d   (stat_lk),
		.q   (stat_core)
	);

	// status bundle seen from the core
	assign stat_lk = '{guard: guard_reg, unlocked: unlock_reg, frozen: frozen_reg,
		cleared: cleared_reg, wen: wen_reg};

	// ****************************************************************
	// variant geometry
	// ****************************************************************
	logic       wide;
	logic [7:0] mask;
	logic [3:0] addr_last;

	// address width and usable bits per variant
	always_comb begin
		wide      = var_lk[1];
		addr_last = wide ? pecd_pkg::WIDE_LAST : pecd_pkg::NARROW_LAST;
		unique case (var_lk)
			2'h0: mask = 8'h0F;
			2'h1: mask = 8'h3F;
			2'h2: mask = 8'h7F;
			2'h3: mask = 8'hFF;
		endcase
	end

	// ****************************************************************
	// instruction decode on the final address or data bit
	// ****************************************************************
	logic [7:0]  a_next;
	logic [15:0] d_next;
	logic [1:0]  top2;
	logic        ones;
	logic        zeros;
	logic        pe_now;
	logic        pre_now;
	logic        addr_done;
	logic        data_done;
	logic        g_ok;
	logic        do_read;
	logic        do_en;
	logic        do_dis;
	logic        do_unl;
	logic        do_clr;
	logic        do_load;
	logic        do_frz;
	logic        need_data;
	logic        do_write;
	logic        do_fill;
	logic        prot;

	// decode of the instruction just completed
	always_comb begin
		a_next    = {addr_reg[6:0], serial_in_pin};
		d_next    = {data_reg[14:0], serial_in_pin};
		top2      = wide ? a_next[7:6] : a_next[5:4];
		ones      = wide ? (a_next == 8'hFF) : (a_next[5:0] == 6'h3F);
		zeros     = wide ? (a_next == 8'h00) : (a_next[5:0] == 6'h00);
		pe_now    = pe_all_reg & program_enable_pin;
		pre_now   = pre_all_reg & guard_select_pin;
		addr_done = (state_reg == pecd_pkg::ST_ADDR) && (cnt_reg == addr_last);
		data_done = (state_reg == pecd_pkg::ST_DATA) && (cnt_reg == pecd_pkg::DATA_LAST);
		g_ok      = unlock_reg & ~frozen_reg & pe_now & pre_now;
		do_read   = addr_done && opc_reg == pecd_pkg::OPC_READ;
		do_en     = addr_done && opc_reg == pecd_pkg::OPC_MISC && top2 == pecd_pkg::TOP_EN
			&& !pre_now && pe_now;
		do_unl    = addr_done && opc_reg == pecd_pkg::OPC_MISC && top2 == pecd_pkg::TOP_EN
			&& pre_now && pe_now && wen_reg;
		do_dis    = addr_done && opc_reg == pecd_pkg::OPC_MISC && top2 == pecd_pkg::TOP_DIS
			&& !pre_now;
		do_frz    = addr_done && opc_reg == pecd_pkg::OPC_MISC && zeros && g_ok;
		do_clr    = addr_done && opc_reg == pecd_pkg::OPC_CLEAR && ones && g_ok;
		do_load   = addr_done && opc_reg == pecd_pkg::OPC_WRITE && g_ok;
		need_data = !pre_now && (opc_reg == pecd_pkg::OPC_WRITE
			|| (opc_reg == pecd_pkg::OPC_MISC && top2 == pecd_pkg::TOP_FILL));
		prot      = !cleared_reg && ((addr_reg & mask) >= (guard_reg & mask));
		do_write  = data_done && opc_reg == pecd_pkg::OPC_WRITE && wen_reg && pe_now
			&& !prot;
		do_fill   = data_done && opc_reg == pecd_pkg::OPC_MISC && wen_reg && pe_now
			&& cleared_reg;
	end

	// ****************************************************************
	// link sequencer, chip select low resets it
	// ****************************************************************
	always_ff @(posedge serial_shift_clock or negedge chip_select) begin
		if (!chip_select) begin
			state_reg <= pecd_pkg::ST_IDLE;
			cnt_reg   <= 4'h0;
		end else begin
			unique case (state_reg)
				pecd_pkg::ST_IDLE: begin
					if (serial_in_pin) begin
						state_reg <= pecd_pkg::ST_OPC;
					end
					cnt_reg <= 4'h0;
				end
				pecd_pkg::ST_OPC: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h1) begin
						state_reg <= pecd_pkg::ST_ADDR;
						cnt_reg   <= 4'h0;
					end
				end
				pecd_pkg::ST_ADDR: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (addr_done) begin
						cnt_reg <= 4'h0;
						if (do_read) begin
							state_reg <= pecd_pkg::ST_READ;
						end else if (need_data) begin
							state_reg <= pecd_pkg::ST_DATA;
						end else begin
							state_reg <= pecd_pkg::ST_HOLD;
						end
					end
				end
				pecd_pkg::ST_DATA: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (data_done) begin
						state_reg <= pecd_pkg::ST_HOLD;
					end
				end
				pecd_pkg::ST_READ: state_reg <= pecd_pkg::ST_READ;
				pecd_pkg::ST_HOLD: state_reg <= pecd_pkg::ST_HOLD;
			endcase
		end
	end

	// opcode, address and data shifters plus pin level tracking
	always_ff @(posedge serial_shift_clock or negedge chip_select) begin
		if (!chip_select) begin
			opc_reg     <= 2'h0;
			addr_reg    <= 8'h00;
			data_reg    <= 16'h0000;
			pe_all_reg  <= 1'b1;
			pre_all_reg <= 1'b1;
		end else begin
			if (state_reg == pecd_pkg::ST_OPC) begin
				opc_reg <= {opc_reg[0], serial_in_pin};
			end
			if (state_reg == pecd_pkg::ST_ADDR) begin
				addr_reg <= a_next;
			end
			if (state_reg == pecd_pkg::ST_DATA) begin
				data_reg <= d_next;
			end
			if (state_reg != pecd_pkg::ST_IDLE) begin
				pe_all_reg  <= pe_now;
				pre_all_reg <= pre_now;
			end
		end
	end

	// ****************************************************************
	// persistent state, reset only by the system reset
	// ****************************************************************
	always_ff @(posedge serial_shift_clock) begin
		if (!lk_rstn) begin
			wen_reg <= 1'b0;
		end else if (do_en) begin
			wen_reg <= 1'b1;
		end else if (do_dis) begin
			wen_reg <= 1'b0;
		end
	end

	// unlock lasts exactly one instruction
	always_ff @(posedge serial_shift_clock) begin
		if (!lk_rstn) begin
			unlock_reg <= 1'b0;
		end else if (addr_done) begin
			unlock_reg <= do_unl;
		end
	end

	// guard address, cleared flag and freeze
	always_ff @(posedge serial_shift_clock) begin
		if (!lk_rstn) begin
			guard_reg   <= pecd_pkg::GUARD_RST;
			cleared_reg <= 1'b1;
			frozen_reg  <= 1'b0;
		end else if (do_clr) begin
			guard_reg   <= pecd_pkg::GUARD_RST;
			cleared_reg <= 1'b1;
		end else if (do_load) begin
			guard_reg   <= a_next & mask;
			cleared_reg <= 1'b0;
		end else if (do_frz) begin
			frozen_reg  <= 1'b1;
		end
	end

	// ****************************************************************
	// word array
	// ****************************************************************
	always_ff @(posedge serial_shift_clock) begin
		if (do_write) begin
			mem[addr_reg & mask] <= d_next;
		end else if (do_fill) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= d_next;
			end
		end
	end

	// ****************************************************************
	// read shifter: dummy zero, then words or guard address
	// ****************************************************************
	logic [7:0] a_mask;
	logic [7:0] nxt_addr;

	assign a_mask   = a_next & mask;
	assign nxt_addr = (rd_addr_reg + 8'h01) & mask;

	always_ff @(posedge serial_shift_clock or negedge chip_select) begin
		if (!chip_select) begin
			serial_out_pin <= 1'b0;
			out_sh_reg     <= 16'h0000;
			out_cnt_reg    <= 5'h00;
			rd_addr_reg    <= 8'h00;
			guard_rd_reg   <= 1'b0;
		end else if (do_read) begin
			serial_out_pin <= 1'b0;
			guard_rd_reg   <= pre_now;
			rd_addr_reg    <= a_mask;
			if (pre_now) begin
				out_sh_reg  <= wide ? {guard_reg, 8'h00} : {guard_reg[5:0], 10'h000};
				out_cnt_reg <= wide ? pecd_pkg::WIDE_BITS : pecd_pkg::NARROW_BITS;
			end else begin
				out_sh_reg  <= mem[a_mask];
				out_cnt_reg <= pecd_pkg::WORD_BITS;
			end
		end else if (state_reg == pecd_pkg::ST_READ) begin
			if (out_cnt_reg == 5'h00) begin
				serial_out_pin <= 1'b0;
			end else begin
				serial_out_pin <= out_sh_reg[15];
				out_sh_reg     <= {out_sh_reg[14:0], 1'b0};
				out_cnt_reg    <= out_cnt_reg - 5'h01;
				if (out_cnt_reg == 5'h01 && !guard_rd_reg) begin
					out_sh_reg  <= mem[nxt_addr];
					out_cnt_reg <= pecd_pkg::WORD_BITS;
					rd_addr_reg <= nxt_addr;
				end
			end
		end
	end

	// drive data out only during a read
	assign serial_out_en = chip_select && (state_reg == pecd_pkg::ST_READ);

	// ****************************************************************
	// apb slave, zero wait states
	// ****************************************************************
	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			pecd_pkg::CTRL_OFS:   rd_val[pecd_pkg::CTRL_VAR_LSB +: 2] = var_reg;
			pecd_pkg::STATUS_OFS: begin
				rd_val[pecd_pkg::ST_WEN_POS] = stat_core.wen;
				rd_val[pecd_pkg::ST_CLR_POS] = stat_core.cleared;
				rd_val[pecd_pkg::ST_FRZ_POS] = stat_core.frozen;
				rd_val[pecd_pkg::ST_UNL_POS] = stat_core.unlocked;
			end
			pecd_pkg::GUARD_OFS:  rd_val[7:0] = stat_core.guard;
			default:              hit = 1'b0;
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	// variant selection written by software
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			var_reg <= pecd_pkg::CTRL_VAR_RST;
		end else if (psel && penable && pwrite && paddr == pecd_pkg::CTRL_OFS) begin
			var_reg <= pwdata[pecd_pkg::CTRL_VAR_LSB +: 2];
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_val;
		end
	end

endmodule : pecd_top

`default_nettype wire

// [bench/pecd_properties.sv]
/* port checker of the decoder, bound into its top.
 * assumes apb on core_clk and the link under chip_select. */
`default_nettype none
module pecd_props (
	input wire logic        core_clk,           // core clock
	input wire logic        resetn,             // sync reset
	input wire logic        psel,               // apb select
	input wire logic        penable,            // apb access
	input wire logic        pwrite,             // apb write
	input wire logic [7:0]  paddr,              // apb address
	input wire logic [31:0] prdata,             // apb read data
	input wire logic        pready,             // apb ready
	input wire logic        pslverr,            // apb error
	input wire logic        serial_shift_clock, // link clock
	input wire logic        chip_select,        // link select
	input wire logic        serial_out_pin,     // link data out
	input wire logic        serial_out_en       // link out enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// helper state
	// ****
	logic       acc;
	logic       map;
	logic       frz_reg;
	logic       cwr_reg;
	logic       gok_reg;
	logic [7:0] ghold_reg;
	assign acc = psel && penable;
	assign map = paddr == pecd_pkg::CTRL_OFS || paddr == pecd_pkg::STATUS_OFS
		|| paddr == pecd_pkg::GUARD_OFS;
	// freeze seen in status, guard value read after it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			frz_reg <= 1'b0;
			gok_reg <= 1'b0;
			ghold_reg <= 8'h00;
		end else if (acc && !pwrite) begin
			if (paddr == pecd_pkg::STATUS_OFS && prdata[pecd_pkg::ST_FRZ_POS])
				frz_reg <= 1'b1;
			if (paddr == pecd_pkg::GUARD_OFS && frz_reg && !gok_reg) begin
				gok_reg <= 1'b1;
				ghold_reg <= prdata[7:0];
			end
		end
	end
	// control written since reset
	always_ff @(posedge core_clk) begin
		if (!resetn)
			cwr_reg <= 1'b0;
		else if (acc && pwrite && paddr == pecd_pkg::CTRL_OFS)
			cwr_reg <= 1'b1;
	end
	// ****
	// assertions
	// ****
	ready_high_a: assert property (@(posedge core_clk) disable iff (!resetn)
		psel |-> pready) else $error("pready low in a transfer");
	unmapped_err_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && !map |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped not refused");
	mapped_ok_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && map |-> !pslverr) else $error("mapped access refused");
	ctrl_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && !pwrite && paddr == pecd_pkg::CTRL_OFS && !cwr_reg
		|-> prdata[1:0] == pecd_pkg::CTRL_VAR_RST) else $error("ctrl reset value wrong");
	status_rsvd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && paddr == pecd_pkg::STATUS_OFS |-> prdata[31:4] == 28'h0)
		else $error("status reserved bits set");
	out_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!chip_select |-> !serial_out_en && !serial_out_pin) else $error("out active unselected");
	frozen_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && paddr == pecd_pkg::STATUS_OFS && frz_reg |-> prdata[pecd_pkg::ST_FRZ_POS])
		else $error("freeze state lost");
	guard_fixed_a: assert property (@(posedge core_clk) disable iff (!resetn)
		acc && paddr == pecd_pkg::GUARD_OFS && gok_reg |-> prdata[7:0] == ghold_reg)
		else $error("guard changed after freeze");
	dummy_bit_a: assert property (@(posedge serial_shift_clock)
		disable iff (!chip_select) $rose(serial_out_en) |-> !serial_out_pin)
		else $error("no zero dummy bit");
endmodule : pecd_props
bind pecd_top pecd_props u_props (.*);
`default_nettype wire

// [bench/pecd_host.sv]
/* host model driving the serial link of the decoder.
 * assumes the bench calls its tasks one at a time. */
`default_nettype none
module pecd_host (
	output logic      sck,  // link clock, still between frames
	output logic      cs,   // chip select
	output logic      sdi,  // serial data in
	output logic      gsel, // guard select pin
	output logic      pen,  // program enable pin
	input  wire logic sdo   // serial data out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// link driving
	// ****
	initial begin
		sck = 1'b0;
		cs = 1'b0;
		sdi = 1'b0;
		gsel = 1'b0;
		pen = 1'b0;
	end
	// one bit, set while low and taken at the rise
	task bitx(input logic b);
		sdi = b;
		#32 sck = 1'b1;
		#32 sck = 1'b0;
	endtask : bitx
	// zero bits in a frame, clocks the link
	task zeros(input int n);
		cs = 1'b1;
		repeat (n) bitx(1'b0);
		cs = 1'b0;
	endtask : zeros
	// one instruction, then rb bits read back
	task xfer(input logic g, input logic p, input logic [1:0] opc, input logic [7:0] adr,
		input int ab, input logic [15:0] dat, input int db, input int rb,
		output logic [47:0] got);
		gsel = g;
		pen = p;
		cs = 1'b1;
		#32;
		bitx(1'b0); // leading zero, ignored
		bitx(1'b1);
		bitx(opc[1]);
		bitx(opc[0]);
		for (int i = ab - 1; i >= 0; i--) bitx(adr[i]);
		for (int i = db - 1; i >= 0; i--) bitx(dat[i]);
		got = 48'h0;
		for (int i = 0; i < rb; i++) begin
			got = {got[46:0], sdo};
			bitx(~sdi);
		end
		#32 cs = 1'b0;
		sdi = ~sdi;
		gsel = ~g;
		pen = ~p;
		#192;
	endtask : xfer
endmodule : pecd_host
`default_nettype wire

// [bench/tb_protected_eeprom_cmd_decoder.sv]
/* bench of the decoder: apb and serial sequences.
 * assumes pecd_top, its checker and the host model. */
`default_nettype none
module tb_protected_eeprom_cmd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CT = pecd_pkg::CTRL_OFS;
	localparam logic [7:0] ST = pecd_pkg::STATUS_OFS;
	localparam logic [7:0] GD = pecd_pkg::GUARD_OFS;
	logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        serial_shift_clock, chip_select, serial_in_pin;
	logic        guard_select_pin, program_enable_pin, serial_out_pin, serial_out_en;
	logic [47:0] got;
	int          ab, err_total, compares;
	pecd_top DUT (.*);
	pecd_host host (.sck(serial_shift_clock), .cs(chip_select), .sdi(serial_in_pin),
		.gsel(guard_select_pin), .pen(program_enable_pin), .sdo(serial_out_pin));
	// ****
	// tasks
	// ****
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		if (n >= 50) begin
			err_total++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input string what, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(what, {16'h0, r}, {16'h0, e});
	endtask : rchk
	task misc(input logic g, input logic p, input logic [1:0] t);
		host.xfer(g, p, pecd_pkg::OPC_MISC, {t, 6'h00} >> (8 - ab), ab, 16'h0, 0, 0, got);
	endtask : misc
	task fill(input logic [15:0] d);
		host.xfer(1'b0, 1'b1, pecd_pkg::OPC_MISC, {pecd_pkg::TOP_FILL, 6'h00} >> (8 - ab),
			ab, d, 16, 0, got);
	endtask : fill
	task wr(input logic g, input logic [7:0] a, input logic [15:0] d);
		host.xfer(g, 1'b1, pecd_pkg::OPC_WRITE, a, ab, d, g ? 0 : 16, 0, got);
	endtask : wr
	task rdw(input logic [7:0] a, input logic [15:0] e);
		host.xfer(1'b0, 1'b0, pecd_pkg::OPC_READ, a, ab, 16'h0, 0, 17, got);
		chk("word", got, {32'h0, e});
	endtask : rdw
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// watchdog
	initial begin
		#400us;
		err_total++;
		wrap_up();
	end
	// ****
	// tests
	// ****
	initial begin
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		ab = 8;
		#1;
		host.zeros(4);
		@(posedge core_clk);
		resetn <= 1'b1;
		rchk("ctrl", CT, 32'h3);
		rchk("status", ST, 32'h2);
		rchk("guard", GD, 32'hFF);
		apb(1'b1, 8'h0C, 32'hFFFFFFFF);
		rchk("unmapped", 8'h0C, 32'h0);
		apb(1'b1, ST, 32'hF);
		rchk("status", ST, 32'h2);
		$display("test registers done");
		misc(1'b0, 1'b1, pecd_pkg::TOP_EN);
		rchk("status", ST, 32'h3);
		fill(16'hC3C3);
		wr(1'b0, 8'h05, 16'hA5A5);
		wr(1'b0, 8'h06, 16'h5A5A);
		misc(1'b0, 1'b0, pecd_pkg::TOP_DIS);
		rchk("status", ST, 32'h2);
		wr(1'b0, 8'h05, 16'h1111);
		host.xfer(1'b0, 1'b0, pecd_pkg::OPC_READ, 8'h05, ab, 16'h0, 0, 33, got);
		chk("sequence", got, 48'h0000A5A55A5A);
		rdw(8'hC8, 16'hC3C3);
		$display("test array done");
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		rchk("status", ST, 32'h2);
		wr(1'b1, 8'h10, 16'h0);
		rchk("guard", GD, 32'hFF);
		misc(1'b0, 1'b1, pecd_pkg::TOP_EN);
		wr(1'b1, 8'h10, 16'h0);
		rchk("guard", GD, 32'hFF);
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		rchk("status", ST, 32'hB);
		wr(1'b1, 8'h10, 16'h0);
		rchk("guard", GD, 32'h10);
		rchk("status", ST, 32'h1);
		host.xfer(1'b1, 1'b0, pecd_pkg::OPC_READ, 8'h00, ab, 16'h0, 0, 9, got);
		chk("guard out", got, 48'h10);
		wr(1'b0, 8'h10, 16'h1111);
		wr(1'b0, 8'h0F, 16'h2222);
		fill(16'h1111);
		rdw(8'h10, 16'hC3C3);
		rdw(8'h0F, 16'h2222);
		rchk("guard", GD, 32'h10);
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		host.xfer(1'b1, 1'b1, pecd_pkg::OPC_CLEAR, 8'hFF, ab, 16'h0, 0, 0, got);
		rchk("guard", GD, 32'hFF);
		rchk("status", ST, 32'h3);
		wr(1'b0, 8'h10, 16'h1111);
		rdw(8'h10, 16'h1111);
		$display("test guard done");
		apb(1'b1, CT, 32'h0);
		ab = 6;
		wr(1'b0, 8'h33, 16'h7777);
		rdw(8'h03, 16'h7777);
		apb(1'b1, CT, 32'h1);
		wr(1'b0, 8'h33, 16'h6666);
		rdw(8'h33, 16'h6666);
		rdw(8'h03, 16'h7777);
		apb(1'b1, CT, 32'h2);
		ab = 8;
		wr(1'b0, 8'h85, 16'h8888);
		rdw(8'h05, 16'h8888);
		apb(1'b1, CT, 32'h3);
		$display("test variants done");
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		wr(1'b1, 8'h20, 16'h0);
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		misc(1'b1, 1'b1, pecd_pkg::TOP_DIS);
		rchk("status", ST, 32'h5);
		rchk("guard", GD, 32'h20);
		misc(1'b1, 1'b1, pecd_pkg::TOP_EN);
		host.xfer(1'b1, 1'b1, pecd_pkg::OPC_CLEAR, 8'hFF, ab, 16'h0, 0, 0, got);
		rchk("guard", GD, 32'h20);
		rchk("status", ST, 32'h5);
		wr(1'b0, 8'h20, 16'h4444);
		rdw(8'h20, 16'hC3C3);
		$display("test freeze done");
		wrap_up();
	end
endmodule : tb_protected_eeprom_cmd_decoder
`default_nettype wire
